// >>> motor_speed_config_registers.sv
// configuration holding registers 14-31 of a motor speed controller
// assumes a decoded holding-register port, lower-bank mode bits on the same clock,
// front-panel switches and trimmers arriving asynchronously
`timescale 1ns/1ps
`include "spd_cfg_params.svh"
// Function
// - minimum level 30-70 percent, reset 30
// - always writable, effective only in bus mode
// - off-level enable 0/1, reset 0
// - off threshold ranges 0-40 and 60-100
// - ascending: 40 means 4.0 V / 8 mA
// - descending: upper span up to 10 V / 20 mA
// - start type soft 0, kick 1, reset 1
// - start duration 0-60 s, reset 10
// - remote function normal/timer, reset 0
// - analogue function normal/logic, reset 0
// - run timer 0-200 s, reset 60
// - timed run follows the start phase
// - timer needs bus mode and a function
// - override level 0 or 30-100, reset 0
// - mode 0 panel, 1 bus, reset panel
// - override enable only in bus mode
module motor_speed_config_registers import spd_cfg_pkg::*; #(
    parameter int SEC_CYCLES = `SECOND_NS / `CORE_CLK_NS
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // holding register port
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wr_data,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_addr_hit,
    // lower-bank settings, same clock
    input wire logic i_operating_mode,
    input wire logic i_override_enable,
    input wire logic i_ascending,
    // measured input and run request, same clock
    input wire logic [9:0] i_analog_counts,
    input wire logic i_run_req,
    // front panel, asynchronous
    input wire logic [6:0] i_panel_min_level,
    input wire logic i_panel_off_enable,
    input wire logic [6:0] i_panel_off_threshold,
    input wire logic i_panel_kick_start,
    // effective settings and status
    output logic [6:0] o_min_level,
    output logic o_off_enable,
    output logic [9:0] o_off_thr_counts,
    output logic o_off_state,
    output logic o_kick_start,
    output logic o_override_active,
    output logic [6:0] o_override_level,
    output logic o_start_active,
    output logic o_run_active,
    output logic o_timed_done
);
    // stored settings
    pct_t min_level_r, min_level_nxt;
    logic off_en_r, off_en_nxt;
    pct_t off_thr_r, off_thr_nxt;
    logic kick_r, kick_nxt;
    logic [5:0] dur_r, dur_nxt;
    logic remote_r, remote_nxt;
    logic analog_r, analog_nxt;
    logic [7:0] tmr_r, tmr_nxt;
    pct_t ovr_r, ovr_nxt;
    // range verdicts on the write data
    logic ok_min, ok_bit, ok_thr_lo, ok_thr_hi, ok_dur, ok_tmr, ok_ovr;
    // panel synchroniser
    logic [15:0] pin_cat, sync1_r, sync2_r;
    pct_t pin_min, pin_thr;
    logic pin_off_en, pin_kick;
    // read port
    logic [15:0] rd_data_nxt;
    logic rd_valid_nxt, hit_nxt;
    // effective outputs
    pct_t min_out_nxt, ovr_out_nxt, thr_eff;
    logic off_en_out_nxt, kick_out_nxt, ovr_act_nxt, off_state_nxt;
    logic [9:0] thr_counts_nxt;
    logic bus_mode;

    seq_if sq ();

    run_sequencer #(.SEC_CYCLES(SEC_CYCLES)) u_seq (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .sq(sq)
    );

    // range checkers, one per distinct range
    value_range_check #(.LO(`RNG_MIN_LO), .HI(`RNG_MIN_HI)) u_rng_min (.i_value(i_wr_data), .o_ok(ok_min));
    value_range_check #(.LO(`RNG_ZERO), .HI(`RNG_BIT_HI)) u_rng_bit (.i_value(i_wr_data), .o_ok(ok_bit));
    value_range_check #(.LO(`RNG_ZERO), .HI(`RNG_OFF_LOW_HI)) u_rng_tlo (.i_value(i_wr_data), .o_ok(ok_thr_lo));
    value_range_check #(.LO(`RNG_OFF_HIGH_LO), .HI(`RNG_OFF_HIGH_HI)) u_rng_thi (.i_value(i_wr_data), .o_ok(ok_thr_hi));
    value_range_check #(.LO(`RNG_ZERO), .HI(`RNG_DUR_HI)) u_rng_dur (.i_value(i_wr_data), .o_ok(ok_dur));
    value_range_check #(.LO(`RNG_ZERO), .HI(`RNG_TMR_HI)) u_rng_tmr (.i_value(i_wr_data), .o_ok(ok_tmr));
    value_range_check #(.LO(`RNG_OVR_LO), .HI(`RNG_OVR_HI)) u_rng_ovr (.i_value(i_wr_data), .o_ok(ok_ovr));

    // panel pins: two flops before any logic looks at them
    always_comb begin
        pin_cat = {i_panel_kick_start, i_panel_off_enable, i_panel_off_threshold, i_panel_min_level};
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
        end else begin
            sync1_r <= pin_cat;
            sync2_r <= sync1_r;
        end
    end

    assign pin_min = sync2_r[6:0];
    assign pin_thr = sync2_r[13:7];
    assign pin_off_en = sync2_r[14];
    assign pin_kick = sync2_r[15];

    assign bus_mode = (i_operating_mode == `MODE_BUS);

    // register writes: accepted in any mode, bad values dropped silently
    always_comb begin
        min_level_nxt = min_level_r;
        off_en_nxt = off_en_r;
        off_thr_nxt = off_thr_r;
        kick_nxt = kick_r;
        dur_nxt = dur_r;
        remote_nxt = remote_r;
        analog_nxt = analog_r;
        tmr_nxt = tmr_r;
        ovr_nxt = ovr_r;
        if (i_wr_en) begin
            case (i_addr)
                `HR_MIN_LEVEL: begin
                    if (ok_min) begin
                        min_level_nxt = i_wr_data[6:0];
                    end
                end
                `HR_OFF_ENABLE: begin
                    if (ok_bit) begin
                        off_en_nxt = i_wr_data[0];
                    end
                end
                `HR_OFF_THRESHOLD: begin
                    if (ok_thr_lo || ok_thr_hi) begin
                        off_thr_nxt = i_wr_data[6:0];
                    end
                end
                `HR_START_TYPE: begin
                    if (ok_bit) begin
                        kick_nxt = i_wr_data[0];
                    end
                end
                `HR_START_DURATION: begin
                    if (ok_dur) begin
                        dur_nxt = i_wr_data[5:0];
                    end
                end
                `HR_REMOTE_FUNC: begin
                    if (ok_bit) begin
                        remote_nxt = i_wr_data[0];
                    end
                end
                `HR_ANALOGUE_FUNC: begin
                    if (ok_bit) begin
                        analog_nxt = i_wr_data[0];
                    end
                end
                `HR_RUN_TIMER: begin
                    if (ok_tmr) begin
                        tmr_nxt = i_wr_data[7:0];
                    end
                end
                `HR_OVERRIDE_LEVEL: begin
                    if (ok_ovr || (i_wr_data == `RNG_ZERO)) begin
                        ovr_nxt = i_wr_data[6:0];
                    end
                end
                default: begin
                    min_level_nxt = min_level_r;
                end
            endcase
        end
    end

    // stored values only change via checked writes
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            min_level_r <= `RST_MIN_LEVEL;
            off_en_r <= `RST_OFF_ENABLE;
            off_thr_r <= `RST_OFF_THRESHOLD;
            kick_r <= `RST_START_TYPE;
            dur_r <= `RST_START_DURATION;
            remote_r <= `RST_REMOTE_FUNC;
            analog_r <= `RST_ANALOGUE_FUNC;
            tmr_r <= `RST_RUN_TIMER;
            ovr_r <= `RST_OVERRIDE_LEVEL;
        end else begin
            min_level_r <= min_level_nxt;
            off_en_r <= off_en_nxt;
            off_thr_r <= off_thr_nxt;
            kick_r <= kick_nxt;
            dur_r <= dur_nxt;
            remote_r <= remote_nxt;
            analog_r <= analog_nxt;
            tmr_r <= tmr_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    // read mux; stored values always read back, whatever the mode
    always_comb begin
        rd_data_nxt = 16'h0000;
        rd_valid_nxt = i_rd_en;
        hit_nxt = (i_rd_en || i_wr_en) && (i_addr >= `HR_MIN_LEVEL) && (i_addr <= `HR_OVERRIDE_LEVEL);
        if (i_rd_en) begin
            case (i_addr)
                `HR_MIN_LEVEL: rd_data_nxt = {9'h000, min_level_r};
                `HR_OFF_ENABLE: rd_data_nxt = {15'h0000, off_en_r};
                `HR_OFF_THRESHOLD: rd_data_nxt = {9'h000, off_thr_r};
                `HR_START_TYPE: rd_data_nxt = {15'h0000, kick_r};
                `HR_START_DURATION: rd_data_nxt = {10'h000, dur_r};
                `HR_REMOTE_FUNC: rd_data_nxt = {15'h0000, remote_r};
                `HR_ANALOGUE_FUNC: rd_data_nxt = {15'h0000, analog_r};
                `HR_RUN_TIMER: rd_data_nxt = {8'h00, tmr_r};
                `HR_OVERRIDE_LEVEL: rd_data_nxt = {9'h000, ovr_r};
                default: rd_data_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rd_data <= 16'h0000;
            o_rd_valid <= 1'b0;
            o_addr_hit <= 1'b0;
        end else begin
            o_rd_data <= rd_data_nxt;
            o_rd_valid <= rd_valid_nxt;
            o_addr_hit <= hit_nxt;
        end
    end

    // effective settings: bus values in bus mode, panel values otherwise
    always_comb begin
        // registers steer only in bus mode
        min_out_nxt = bus_mode ? min_level_r : pin_min;
        off_en_out_nxt = bus_mode ? off_en_r : pin_off_en;
        thr_eff = bus_mode ? off_thr_r : pin_thr;
        kick_out_nxt = bus_mode ? kick_r : pin_kick;
        // one step is 10 counts, 40 maps to 4.0 V / 8 mA
        // both input types span 1000 counts, so the type needs no separate scale
        thr_counts_nxt = {3'h0, thr_eff} * `THR_COUNT_SCALE;
        // descending: output off above the threshold instead of below
        if (i_ascending) begin
            off_state_nxt = off_en_out_nxt && (i_analog_counts < thr_counts_nxt);
        end else begin
            off_state_nxt = off_en_out_nxt && (i_analog_counts > thr_counts_nxt);
        end
        // override needs bus mode as well
        ovr_act_nxt = bus_mode && i_override_enable;
        // override level only while override enabled
        ovr_out_nxt = ovr_act_nxt ? ovr_r : 7'h00;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_min_level <= `RST_MIN_LEVEL;
            o_off_enable <= 1'b0;
            o_off_thr_counts <= 10'h000;
            o_off_state <= 1'b0;
            o_kick_start <= `RST_START_TYPE;
            o_override_active <= 1'b0;
            o_override_level <= 7'h00;
        end else begin
            o_min_level <= min_out_nxt;
            o_off_enable <= off_en_out_nxt;
            o_off_thr_counts <= thr_counts_nxt;
            o_off_state <= off_state_nxt;
            o_kick_start <= kick_out_nxt;
            o_override_active <= ovr_act_nxt;
            o_override_level <= ovr_out_nxt;
        end
    end

    // sequencer settings; panel mode has no duration setting, so the default holds
    assign sq.start_secs = bus_mode ? dur_r : `RST_START_DURATION;
    assign sq.timer_secs = tmr_r;
    // timer gated by mode and functions
    assign sq.timer_en = bus_mode && (remote_r || analog_r);
    assign sq.run_req = i_run_req;
    // status flops live in the sequencer
    assign o_start_active = sq.start_active;
    assign o_run_active = sq.run_active;
    assign o_timed_done = sq.timed_done;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    rd_answer_a: assert property (i_rd_en |=> o_rd_valid)
        else $error("read not answered next cycle");
    rsvd_zero_a: assert property (i_rd_en && (i_addr >= `HR_RSVD_FIRST) && (i_addr <= `HR_RSVD_LAST) |=> o_rd_data == 16'h0000)
        else $error("reserved location read nonzero");
    reset_defaults_a: assert property ($past(i_sys_rst) |-> min_level_r == `RST_MIN_LEVEL && kick_r && dur_r == `RST_START_DURATION && tmr_r == `RST_RUN_TIMER && !off_en_r)
        else $error("reset defaults wrong");
    min_reject_a: assert property (i_wr_en && i_addr == `HR_MIN_LEVEL && (i_wr_data < `RNG_MIN_LO || i_wr_data > `RNG_MIN_HI) |=> $stable(min_level_r))
        else $error("out-of-range minimum level stored");
    tmr_write_a: assert property (i_wr_en && i_addr == `HR_RUN_TIMER && i_wr_data <= `RNG_TMR_HI |=> tmr_r == $past(i_wr_data[7:0]))
        else $error("valid timer write not stored");
    thr_band_a: assert property (##1 (off_thr_r <= `RNG_OFF_LOW_HI) || (off_thr_r >= `RNG_OFF_HIGH_LO && off_thr_r <= `RNG_OFF_HIGH_HI))
        else $error("threshold outside permitted bands");
    sequence bus_steady_s;
        bus_mode [*2];
    endsequence
    bus_select_a: assert property (bus_steady_s |=> o_min_level == $past(min_level_r) && o_kick_start == $past(kick_r))
        else $error("bus settings not applied in bus mode");
    thr_scale_a: assert property (bus_mode |=> o_off_thr_counts == $past(off_thr_r) * `THR_COUNT_SCALE)
        else $error("threshold scaling wrong");
    ovr_gate_a: assert property (o_override_active |-> $past(i_operating_mode) && $past(i_override_enable))
        else $error("override active outside bus mode");
    ovr_zero_a: assert property (!o_override_active |-> o_override_level == 7'h00)
        else $error("override level shown while disabled");
    dur_range_a: assert property (##1 dur_r <= `RNG_DUR_HI)
        else $error("start duration above 60");
endmodule : motor_speed_config_registers

// >>> spd_cfg_params.svh
// constants of the speed-controller configuration bank: addresses, resets, ranges, timing
// assumes 16-bit holding-register addressing and a 50 MHz core clock
`ifndef SPD_CFG_PARAMS_SVH
`define SPD_CFG_PARAMS_SVH

// holding register addresses
`define HR_MIN_LEVEL 16'h000e
`define HR_OFF_ENABLE 16'h000f
`define HR_OFF_THRESHOLD 16'h0010
`define HR_START_TYPE 16'h0011
`define HR_START_DURATION 16'h0012
`define HR_REMOTE_FUNC 16'h0013
`define HR_ANALOGUE_FUNC 16'h0014
`define HR_RUN_TIMER 16'h0015
`define HR_RSVD_FIRST 16'h0016
`define HR_RSVD_LAST 16'h001e
`define HR_OVERRIDE_LEVEL 16'h001f

// reset values
`define RST_MIN_LEVEL 7'h1e
`define RST_OFF_ENABLE 1'h0
`define RST_OFF_THRESHOLD 7'h00
`define RST_START_TYPE 1'h1
`define RST_START_DURATION 6'h0a
`define RST_REMOTE_FUNC 1'h0
`define RST_ANALOGUE_FUNC 1'h0
`define RST_RUN_TIMER 8'h3c
`define RST_OVERRIDE_LEVEL 7'h00

// permitted write ranges
`define RNG_ZERO 16'h0000
`define RNG_BIT_HI 16'h0001
`define RNG_MIN_LO 16'h001e
`define RNG_MIN_HI 16'h0046
`define RNG_OFF_LOW_HI 16'h0028
`define RNG_OFF_HIGH_LO 16'h003c
`define RNG_OFF_HIGH_HI 16'h0064
`define RNG_DUR_HI 16'h003c
`define RNG_TMR_HI 16'h00c8
`define RNG_OVR_LO 16'h001e
`define RNG_OVR_HI 16'h0064

// mode selector value for bus control, threshold scale to input counts
`define MODE_BUS 1'h1
`define THR_COUNT_SCALE 10'h00a

// one second in ns, core clock period in ns
`define SECOND_NS 1000000000
`define CORE_CLK_NS 20

`endif

// >>> spd_cfg_pkg.sv
// types shared by the configuration bank and its start/timer sequencer
// assumes the constants header is included by each design file
package spd_cfg_pkg;
    // sequencer states, gray along idle-start-timed-hold
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_START = 2'b01,
        SEQ_TIMED = 2'b11,
        SEQ_HOLD = 2'b10
    } seq_state_e;
    typedef logic [6:0] pct_t;
endpackage : spd_cfg_pkg

// >>> seq_if.sv
// settings and status passed between the register bank and the run sequencer
// assumes both ends sit on i_core_clk
`timescale 1ns/1ps
interface seq_if;
    logic [5:0] start_secs;
    logic [7:0] timer_secs;
    logic timer_en;
    logic run_req;
    logic start_active;
    logic run_active;
    logic timed_done;
    modport ctl (output start_secs, timer_secs, timer_en, run_req, input start_active, run_active, timed_done);
    modport seq (input start_secs, timer_secs, timer_en, run_req, output start_active, run_active, timed_done);
endinterface : seq_if

// >>> value_range_check.sv
// checks one written value against an inclusive range
// assumes bounds given as 16-bit parameters
`timescale 1ns/1ps
module value_range_check #(
    parameter logic [15:0] LO = 16'h0000,
    parameter logic [15:0] HI = 16'h0001
) (
    // value under test
    input wire logic [15:0] i_value,
    // verdict
    output logic o_ok
);
    // purely combinational, a write commits on the same edge
    assign o_ok = (i_value >= LO) && (i_value <= HI);
endmodule : value_range_check

// >>> run_sequencer.sv
// start ramp / kick interval followed by the optional timed run
// assumes a same-clock run request level and settings from the bank
`timescale 1ns/1ps
`include "spd_cfg_params.svh"
module run_sequencer import spd_cfg_pkg::*; #(
    parameter int SEC_CYCLES = `SECOND_NS / `CORE_CLK_NS
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // settings in, status out
    seq_if.seq sq
);
    seq_state_e state_r, state_nxt;
    logic [25:0] cyc_r, cyc_nxt;
    logic [7:0] secs_r, secs_nxt;
    logic start_r, start_nxt, run_r, run_nxt, done_r, done_nxt;
    logic tick;

    // one-second tick, restarted at each phase entry
    assign tick = (cyc_r == 26'(SEC_CYCLES - 1));

    // next state; dropping the request aborts from any state
    always_comb begin
        state_nxt = state_r;
        cyc_nxt = tick ? 26'h0000000 : cyc_r + 26'h0000001;
        secs_nxt = tick ? secs_r + 8'h01 : secs_r;
        case (state_r)
            SEQ_IDLE: begin
                cyc_nxt = 26'h0000000;
                secs_nxt = 8'h00;
                if (sq.run_req) begin
                    state_nxt = SEQ_START;
                end
            end
            SEQ_START: begin
                if (secs_r >= {2'h0, sq.start_secs}) begin
                    state_nxt = sq.timer_en ? SEQ_TIMED : SEQ_HOLD;
                    cyc_nxt = 26'h0000000;
                    secs_nxt = 8'h00;
                end
            end
            // losing the enable ends the timed run
            SEQ_TIMED: begin
                if (!sq.timer_en || (secs_r >= sq.timer_secs)) begin
                    state_nxt = SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                cyc_nxt = 26'h0000000;
            end
            default: begin
                state_nxt = SEQ_IDLE;
            end
        endcase
        if (!sq.run_req) begin
            state_nxt = SEQ_IDLE;
        end
        start_nxt = (state_nxt == SEQ_START);
        done_nxt = (state_nxt == SEQ_HOLD) && sq.timer_en;
        run_nxt = (state_nxt == SEQ_START) || (state_nxt == SEQ_TIMED) || ((state_nxt == SEQ_HOLD) && !sq.timer_en);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_r <= SEQ_IDLE;
            cyc_r <= 26'h0000000;
            secs_r <= 8'h00;
            start_r <= 1'b0;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
            secs_r <= secs_nxt;
            start_r <= start_nxt;
            run_r <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign sq.start_active = start_r;
    assign sq.run_active = run_r;
    assign sq.timed_done = done_r;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    sequence idle_req_s;
        (state_r == SEQ_IDLE) && sq.run_req;
    endsequence
    start_entry_a: assert property (idle_req_s |=> sq.start_active)
        else $error("start phase not entered on run request");
    // timed run only after a finished start phase
    no_overlap_a: assert property ($rose(state_r == SEQ_TIMED) |-> ($past(state_r) == SEQ_START) && ($past(secs_r) >= {2'h0, $past(sq.start_secs)}))
        else $error("timed run overlaps start phase");
    timed_gate_a: assert property ((state_r == SEQ_TIMED) |-> $past(sq.timer_en))
        else $error("timed run without timer enable");
endmodule : run_sequencer

// >>> mb_master.sv
// far-side master model: single-cycle holding register reads and writes
// assumes the bank takes a strobe at the rising edge it is sampled high
`timescale 1ns/1ps
module mb_master (
    // clock
    input wire logic i_core_clk,
    // register port
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [15:0] o_addr,
    output logic [15:0] o_wr_data
);
    // idle bus at time zero
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 16'h0000;
        o_wr_data = 16'h0000;
    end

    // one-cycle access; released lines flip so a stale value never matches
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        o_wr_en <= w;
        o_rd_en <= ~w;
        o_addr <= a;
        o_wr_data <= d;
        @(posedge i_core_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_addr <= ~a;
        o_wr_data <= ~d;
    endtask : xfer
endmodule : mb_master

// >>> motor_speed_config_registers_tb.sv
// self-checking bench for the speed-controller configuration bank
// assumes the master model of mb_master.sv and a second shortened to 4 cycles
`timescale 1ns/1ps
module motor_speed_config_registers_tb;
    // stimulus
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic wr_en, rd_en;
    logic [15:0] addr, wr_data, rd_data, v;
    logic mode = 1'b0, ovr_en = 1'b0, asc = 1'b1, run_req = 1'b0;
    logic [9:0] cnt = 10'h000;
    logic [6:0] pmin = 7'h32;
    // observed outputs
    logic rd_valid, hit, off_en, off_st, kick, ovr_act, st_act, run_act, t_done;
    logic [6:0] min_level, ovr_lvl;
    logic [9:0] thr_cnt;
    // bookkeeping and tables
    logic [16:0] exp_q[$];
    logic [16:0] e_hd;
    logic [31:0] seed = 32'ha826cdca;
    int miscompares = 0, n_compared = 0, n;
    logic [15:0] rv[9] = '{16'h001e, 16'h0000, 16'h0000, 16'h0001, 16'h000a, 16'h0000, 16'h0000, 16'h003c, 16'h0000};
    logic [15:0] ba[6] = '{16'h000e, 16'h001f, 16'h0010, 16'h0012, 16'h0015, 16'h0016};
    logic [15:0] bv[6] = '{16'h0047, 16'h001d, 16'h0029, 16'h003d, 16'h00c9, 16'h1234};
    logic [15:0] be[6] = '{16'h001e, 16'h0000, 16'h0000, 16'h000a, 16'h003c, 16'h0000};

    always #10 i_core_clk = ~i_core_clk;

    mb_master mst_u (.i_core_clk(i_core_clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));

    // panel off-level and start-type pins held at their idle settings
    motor_speed_config_registers #(.SEC_CYCLES(4)) dut_u (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_addr_hit(hit),
        .i_operating_mode(mode), .i_override_enable(ovr_en), .i_ascending(asc), .i_analog_counts(cnt),
        .i_run_req(run_req), .i_panel_min_level(pmin), .i_panel_off_enable(1'b0),
        .i_panel_off_threshold(7'h00), .i_panel_kick_start(1'b1), .o_min_level(min_level),
        .o_off_enable(off_en), .o_off_thr_counts(thr_cnt), .o_off_state(off_st), .o_kick_start(kick),
        .o_override_active(ovr_act), .o_override_level(ovr_lvl), .o_start_active(st_act),
        .o_run_active(run_act), .o_timed_done(t_done));

    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk_lv(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_lv

    task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
        chk_lv("rd_data", e, g);
    endtask : chk_rd

    // reads note their expectation before the strobe goes out
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        exp_q.push_back({(a >= 16'h000e) && (a <= 16'h001f), e});
        mst_u.xfer(1'b0, a, 16'h0000);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        mst_u.xfer(1'b1, a, d);
    endtask : wr

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // read results taken mid-cycle, away from the launching edge
    always @(negedge i_core_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk_lv("unexpected_read", 16'h0000, 16'hffff);
            end else begin
                e_hd = exp_q.pop_front();
                chk_rd(e_hd[15:0], rd_data);
                chk_lv("addr_hit", 16'(e_hd[16]), 16'(hit));
            end
        end
    end

    // a full run is under 600 cycles; 10000 means a hang
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            rd((k < 8) ? 16'h000e + 16'(k) : 16'h001f, rv[k]);
        end
        rd(16'h0028, 16'h0000);
        $display("test reset values done");
        for (int k = 0; k < 6; k++) begin
            wr(ba[k], bv[k]);
            rd(ba[k], be[k]);
        end
        v = 16'h001e + 16'(rnd() % 41);
        wr(16'h000e, v);
        rd(16'h000e, v);
        wr(16'h001f, 16'h0064);
        wr(16'h000f, 16'h0001);
        wr(16'h0010, 16'h0028);
        rd(16'h0010, 16'h0028);
        wr(16'h0011, 16'h0000);
        $display("test ranges done");
        mode <= 1'b1;
        ovr_en <= 1'b1;
        cnt <= 10'(rnd() % 1001);
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk_lv("min_level", v, 16'(min_level));
        chk_lv("thr_counts", 16'd400, 16'(thr_cnt));
        chk_lv("off_asc", 16'(cnt < 10'd400), 16'(off_st));
        chk_lv("ovr_level", 16'h0064, 16'(ovr_lvl));
        chk_lv("kick_bus", 16'h0000, 16'(kick));
        @(posedge i_core_clk);
        asc <= 1'b0;
        repeat (3) @(negedge i_core_clk);
        chk_lv("off_desc", 16'(cnt > 10'd400), 16'(off_st));
        @(posedge i_core_clk);
        mode <= 1'b0;
        repeat (4) @(negedge i_core_clk);
        chk_lv("panel_min", 16'h0032, 16'(min_level));
        chk_lv("panel_ovr", 16'h0000, 16'(ovr_act));
        chk_lv("panel_off", 16'h0000, 16'(off_en));
        chk_lv("kick_panel", 16'h0001, 16'(kick));
        $display("test effective settings done");
        wr(16'h0012, 16'h0001);
        wr(16'h0013, 16'h0001);
        wr(16'h0015, 16'h0001);
        mode <= 1'b1;
        run_req <= 1'b1;
        // start 1 s then timer 1 s, each about 5 cycles
        for (n = 0; n < 100 && t_done !== 1'b1; n++) begin
            @(negedge i_core_clk);
        end
        chk_lv("timed_span", 16'h0001, 16'(n >= 8 && n <= 20));
        chk_lv("run_after", 16'h0000, 16'(run_act));
        @(posedge i_core_clk);
        run_req <= 1'b0;
        mode <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        run_req <= 1'b1;
        repeat (3) @(negedge i_core_clk);
        chk_lv("panel_start", 16'h0001, 16'(st_act));
        repeat (77) @(negedge i_core_clk);
        chk_lv("panel_done", 16'h0000, 16'(t_done));
        chk_lv("panel_run", 16'h0001, 16'(run_act));
        chk_lv("panel_start_end", 16'h0000, 16'(st_act));
        $display("test sequencer done");
        give_verdict();
    end
endmodule : motor_speed_config_registers_tb
